// [include/swc_defines.svh]
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

// Expanded register file, bank F
`define SWC_ADDR_WAKE_CFG 8'h0B
`define SWC_ADDR_WAKE_CFG2 8'h0D

// Field positions
`define SWC_BIT_FLAG 7
`define SWC_BIT_POL 6
`define SWC_BIT_DLY 5
`define SWC_SRC_HI 4
`define SWC_SRC_LO 2
`define SWC_BIT_DIV 0

// Reset values
`define SWC_WAKE_CFG_RST 8'h00
`define SWC_WAKE_CFG2_RST 8'h00

// Source codes
`define SWC_SRC_POR_ONLY 3'h0
`define SWC_SRC_P2_NAND4 3'h1
`define SWC_SRC_P2_NAND8 3'h2
`define SWC_SRC_P3_NOR 3'h3
`define SWC_SRC_P3_NAND 3'h4
`define SWC_SRC_P30_NOR 3'h5
`define SWC_SRC_P30_NAND 3'h6
`define SWC_SRC_P32_NAND 3'h7

// Recovery reset delays in clock cycles
`define SWC_DLY_SHORT_CYC 16
`define SWC_DLY_LONG_CYC 64

`endif

// [include/swc_pkg.sv]
package swc_pkg;

  typedef enum logic [1:0] {
    SWC_RUN = 2'b00,
    SWC_STOP = 2'b01,
    SWC_DELAY = 2'b10
  } swc_state_t;

  typedef struct packed {
    logic pol;
    logic dly;
    logic [2:0] src;
    logic div;
  } swc_cfg_t;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p0_is_out;
    logic [7:0] p2;
    logic [7:0] p2_is_out;
    logic [3:1] p3;
  } swc_pins_t;

endpackage

// [src/swc_stop_wake.sv]
// Functional notes
// - Flag set on stop exit, cleared by reset
// - Config bits write-only, flag bit read-only
// - Bit 6 picks low or high wake level
// - Bit 5 picks the recovery reset delay
// - Bits 4..2 select the wake source
// - Bit 0 divides system and timer clocks
// - Source codes 000 to 100 decode as listed
// - Codes 101/110 add port 0 bits 0,7
// - Code 111 adds port 2 bits 2..0
// - Pins configured as outputs are ignored
// - Second register resets to zero, reserved zero
// - Either register's source can wake alone
`timescale 1ns/1ps
`default_nettype none
`include "swc_defines.svh"

module swc_stop_wake #(
  parameter int unsigned SHORT_DLY_CYC = `SWC_DLY_SHORT_CYC,
  parameter int unsigned LONG_DLY_CYC = `SWC_DLY_LONG_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_stop_req,
  input wire swc_pkg::swc_pins_t i_pins,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_stop_mode,
  output logic o_recovery_rst,
  output logic o_wake_done,
  output logic o_clk_div16
);

  localparam int unsigned CW = 16;

  swc_pkg::swc_cfg_t cfg_q;
  swc_pkg::swc_cfg_t cfg2_q;
  swc_pkg::swc_state_t state_q;
  swc_pkg::swc_state_t state_d;
  logic flag_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic stop_q;
  logic rst_out_q;
  logic done_q;
  logic div_q;

  // Register decode
  wire sel_cfg = i_reg_addr == `SWC_ADDR_WAKE_CFG;
  wire sel_cfg2 = i_reg_addr == `SWC_ADDR_WAKE_CFG2;
  wire wr_cfg = i_ce & i_reg_wr & sel_cfg;
  wire wr_cfg2 = i_ce & i_reg_wr & sel_cfg2;
  // Only the flag is visible; everything else reads as zero
  wire [7:0] rd_mux = sel_cfg ? {flag_q, 7'h00} : 8'h00;

  // Pins driven as outputs are forced to the neutral value of each gate
  wire [7:0] p0_nand = i_pins.p0 | i_pins.p0_is_out;
  wire [7:0] p0_nor = i_pins.p0 & ~i_pins.p0_is_out;
  wire [7:0] p2_nand = i_pins.p2 | i_pins.p2_is_out;
  wire [3:1] p3 = i_pins.p3;

  wire g_p2_lo4 = ~&p2_nand[3:0];
  wire g_p2_all = ~&p2_nand;
  wire g_p3_nor = ~|p3;
  wire g_p3_nand = ~&p3;
  wire g_p30_nor = ~|{p3, p0_nor[7], p0_nor[0]};
  wire g_p30_nand = ~&{p3, p0_nand[7], p0_nand[0]};
  wire g_p32_nand = ~&{p3, p2_nand[2:0]};

  function automatic logic src_match(input logic [2:0] src, input logic pol, input logic [7:1] g);
    logic gate;
    gate = 1'b0;
    unique case (src)
      `SWC_SRC_POR_ONLY: gate = 1'b0;
      `SWC_SRC_P2_NAND4: gate = g[1];
      `SWC_SRC_P2_NAND8: gate = g[2];
      `SWC_SRC_P3_NOR: gate = g[3];
      `SWC_SRC_P3_NAND: gate = g[4];
      `SWC_SRC_P30_NOR: gate = g[5];
      `SWC_SRC_P30_NAND: gate = g[6];
      `SWC_SRC_P32_NAND: gate = g[7];
    endcase
    // Level at the xor input: pol 0 wakes on low, pol 1 on high
    src_match = (src != `SWC_SRC_POR_ONLY) && (gate == pol);
  endfunction

  wire [7:1] gates = {g_p32_nand, g_p30_nand, g_p30_nor, g_p3_nand, g_p3_nor, g_p2_all, g_p2_lo4};
  wire wake1 = src_match(cfg_q.src, cfg_q.pol, gates);
  wire wake2 = src_match(cfg2_q.src, cfg2_q.pol, gates);
  wire wake_any = wake1 | wake2;

  wire [CW-1:0] dly_load = cfg_q.dly ? CW'(LONG_DLY_CYC - 1) : CW'(SHORT_DLY_CYC - 1);
  wire dly_end = (state_q == swc_pkg::SWC_DELAY) && (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      swc_pkg::SWC_RUN: begin
        if (i_stop_req) begin
          state_d = swc_pkg::SWC_STOP;
        end
      end
      swc_pkg::SWC_STOP: begin
        // Level sensed every cycle, first match wins
        if (wake_any) begin
          state_d = swc_pkg::SWC_DELAY;
          cnt_d = dly_load;
        end
      end
      swc_pkg::SWC_DELAY: begin
        if (cnt_q == '0) begin
          state_d = swc_pkg::SWC_RUN;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = swc_pkg::SWC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= swc_pkg::swc_cfg_t'(6'h00);
      cfg2_q <= swc_pkg::swc_cfg_t'(6'h00);
    end else if (i_ce) begin
      if (wr_cfg) begin
        cfg_q <= {i_reg_wdata[`SWC_BIT_POL], i_reg_wdata[`SWC_BIT_DLY],
                  i_reg_wdata[`SWC_SRC_HI:`SWC_SRC_LO], i_reg_wdata[`SWC_BIT_DIV]};
      end
      // Reserved bits are not stored, so they can never steer anything
      if (wr_cfg2) begin
        cfg2_q <= {i_reg_wdata[`SWC_BIT_POL], 1'b0, i_reg_wdata[`SWC_SRC_HI:`SWC_SRC_LO], 1'b0};
      end
    end
  end

  // Flag survives stop recovery; only power-on reset clears it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (i_ce && dly_end) begin
      flag_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= swc_pkg::SWC_RUN;
      cnt_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      stop_q <= 1'b0;
      rst_out_q <= 1'b0;
      done_q <= 1'b0;
      div_q <= 1'b0;
    end else if (i_ce) begin
      rdata_q <= i_reg_rd ? rd_mux : 8'h00;
      rvalid_q <= i_reg_rd;
      // Mirrors state_q so the stop indication leaves a flip-flop directly
      stop_q <= state_d == swc_pkg::SWC_STOP;
      rst_out_q <= state_d == swc_pkg::SWC_DELAY;
      done_q <= dly_end;
      div_q <= wr_cfg ? i_reg_wdata[`SWC_BIT_DIV] : cfg_q.div;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_stop_mode = stop_q;
  assign o_recovery_rst = rst_out_q;
  assign o_wake_done = done_q;
  assign o_clk_div16 = div_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_flag_sticky: assert property (flag_q |=> flag_q)
    else $error("recovery flag dropped without reset");
  a_flag_on_exit: assert property ((i_ce && dly_end) |=> flag_q && o_wake_done && state_q == swc_pkg::SWC_RUN)
    else $error("flag or run state missing after recovery");
  a_read_only_flag: assert property ((i_ce && i_reg_rd) |=> o_reg_rvalid && o_reg_rdata[6:0] == 7'h00)
    else $error("write-only bits visible on read");
  a_level_wake: assert property ((i_ce && state_q == swc_pkg::SWC_STOP && wake_any) |=> state_q == swc_pkg::SWC_DELAY && o_recovery_rst)
    else $error("matching level did not start recovery");
  a_no_false_wake: assert property ((i_ce && state_q == swc_pkg::SWC_STOP && !wake_any) |=> state_q == swc_pkg::SWC_STOP)
    else $error("left stop without a wake match");
  a_delay_load: assert property ((i_ce && state_q == swc_pkg::SWC_STOP && wake_any) |=> cnt_q == ($past(cfg_q.dly) ? CW'(LONG_DLY_CYC - 1) : CW'(SHORT_DLY_CYC - 1)))
    else $error("wrong recovery delay selected");
  a_rst_tracks: assert property (o_recovery_rst == (state_q == swc_pkg::SWC_DELAY))
    else $error("recovery reset out of step with delay state");
  a_por_only: assert property ((cfg_q.src == `SWC_SRC_POR_ONLY && cfg2_q.src == `SWC_SRC_POR_ONLY) |-> !wake_any)
    else $error("wake with no source selected");
  a_out_ignored: assert property ((cfg2_q.src == `SWC_SRC_POR_ONLY && cfg_q.src == `SWC_SRC_P2_NAND4 && !cfg_q.pol && &i_pins.p2_is_out[3:0]) |-> !wake_any)
    else $error("output pin took part in wake");
  a_div_write: assert property (wr_cfg |=> o_clk_div16 == $past(i_reg_wdata[`SWC_BIT_DIV]))
    else $error("divide select not applied");
  a_cfg2_reset: assert property ($past(i_rst) |-> cfg2_q.src == 3'h0 && !cfg2_q.pol)
    else $error("second register reset value wrong");

  c_wake_first: cover property (state_q == swc_pkg::SWC_STOP && wake1 && !wake2 ##1 state_q == swc_pkg::SWC_DELAY);
  c_wake_second: cover property (state_q == swc_pkg::SWC_STOP && wake2 && !wake1 ##1 state_q == swc_pkg::SWC_DELAY);
  c_long_exit: cover property (cfg_q.dly && dly_end ##1 flag_q);

endmodule

`default_nettype wire

// [tb/swc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

module swc_pin_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  output var swc_pkg::swc_pins_t o_pins
);
  logic [63:0] ra;
  logic [63:0] rb;

  // Random patterns lean to ones or zeros so wide gates still settle both ways.
  // Solid modes hold every pin as an input at one level, which always settles a gate.
  always @(negedge i_clk) begin
    ra = {$urandom, $urandom};
    rb = {$urandom, $urandom};
    if (i_mode[1]) begin
      o_pins <= {{8{i_mode[0]}}, 8'h00, {8{i_mode[0]}}, 8'h00, {3{i_mode[0]}}};
    end else if (ra[0]) begin
      o_pins <= ra[1] ? (ra[34:0] | rb[34:0]) : (ra[34:0] & rb[34:0]);
    end
  end
endmodule

`default_nettype wire

// [tb/swc_stop_wake_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module swc_stop_wake_tb;
  localparam int unsigned SHORT_CYC = 2;
  localparam int unsigned LONG_CYC = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_stop_req = 1'b0;
  logic [1:0] pin_mode = 2'b11;
  swc_pkg::swc_pins_t pins;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid, o_stop_mode, o_recovery_rst, o_wake_done, o_clk_div16;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  logic [2:0] s1, s2;
  logic p1, p2, d1, dv, m;

  swc_stop_wake #(.SHORT_DLY_CYC(SHORT_CYC), .LONG_DLY_CYC(LONG_CYC)) i_swc_stop_wake (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_stop_req(i_stop_req), .i_pins(pins),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_stop_mode(o_stop_mode),
    .o_recovery_rst(o_recovery_rst), .o_wake_done(o_wake_done), .o_clk_div16(o_clk_div16)
  );

  swc_pin_model i_swc_pin_model (.i_clk(i_clk), .i_mode(pin_mode), .o_pins(pins));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, o_reg_rvalid});
    chk("rdata", exp, o_reg_rdata);
  endtask

  // Output pins count as the neutral level of their gate
  function automatic logic wk(input logic [2:0] s, input logic pl, input swc_pkg::swc_pins_t p);
    logic [7:0] a2, a0, z0;
    logic g;
    a2 = p.p2 | p.p2_is_out;
    a0 = p.p0 | p.p0_is_out;
    z0 = p.p0 & ~p.p0_is_out;
    case (s)
      3'h1: g = ~&a2[3:0];
      3'h2: g = ~&a2;
      3'h3: g = ~|p.p3;
      3'h4: g = ~&p.p3;
      3'h5: g = ~|{p.p3, z0[0], z0[7]};
      3'h6: g = ~&{p.p3, a0[0], a0[7]};
      3'h7: g = ~&{p.p3, a2[2:0]};
      default: g = ~pl;
    endcase
    return g == pl;
  endfunction

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h0000_13e6));
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    rd(8'h0B, 8'h00);
    rd(8'h0D, 8'h00);
    rd(8'h3C, 8'h00);
    for (int t = 0; t < 24; t++) begin
      {p1, p2, d1, dv} = 4'($urandom);
      s1 = 3'($urandom);
      s2 = 3'($urandom);
      // First eight passes walk every code in the first register, alone except code 0, which pairs with code 1 in the second
      if (t < 8) begin
        s1 = t[2:0];
        s2 = (t == 0) ? 3'h1 : 3'h0;
      end
      if (s1 == 3'h0 && s2 == 3'h0) s2 = 3'h7;
      wr(8'h0B, {1'b1, p1, d1, s1, 1'b0, dv});
      wr(8'h0D, {1'b0, p2, 1'b0, s2, 2'b00});
      chk("divide", {7'h00, dv}, {7'h00, o_clk_div16});
      pin_mode = 2'b00;
      @(negedge i_clk) i_stop_req = 1'b1;
      @(negedge i_clk) i_stop_req = 1'b0;
      chk("stop", 8'h01, {7'h00, o_stop_mode});
      m = 1'b0;
      for (int c = 0; c < 300 && !m; c++) begin
        @(posedge i_clk);
        m = wk(s1, p1, pins) | wk(s2, p2, pins);
        @(negedge i_clk);
        if (c == 60) pin_mode = {1'b1, (s1 != 3'h0) ? ~p1 : ~p2};
        chk("stop", {7'h00, !m}, {7'h00, o_stop_mode});
        chk("recovery", {7'h00, m}, {7'h00, o_recovery_rst});
      end
      n = 0;
      while (o_recovery_rst === 1'b1 && n < 100) begin
        n++;
        @(negedge i_clk);
      end
      chk("delay", 8'(d1 ? LONG_CYC : SHORT_CYC), 8'(n));
      chk("done", 8'h01, {7'h00, o_wake_done});
      rd(8'h0B, 8'h80);
      $display("test %0d done", t);
    end
    // Clock enable low: a write must leave the divide select alone
    i_ce = 1'b0;
    wr(8'h0B, {7'h00, ~dv});
    chk("divide", {7'h00, dv}, {7'h00, o_clk_div16});
    i_ce = 1'b1;
    $display("test freeze done");
    @(negedge i_clk) i_rst = 1'b1;
    @(negedge i_clk) i_rst = 1'b0;
    rd(8'h0B, 8'h00);
    chk("divide", 8'h00, {7'h00, o_clk_div16});
    conclude();
  end
endmodule

`default_nettype wire
